// [cmp_pkg.sv]
package cmp_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR  = 8'h9B;
  localparam logic [7:0] MODE_ADDR  = 8'h9D;
  localparam logic [7:0] RESET_ADDR = 8'hEF;

  // control register fields
  localparam int CTRL_ON_BIT     = 7;
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_UP_BIT     = 5;
  localparam int CTRL_DOWN_BIT   = 4;
  localparam int CTRL_PHYST_HI   = 3;
  localparam int CTRL_PHYST_LO   = 2;
  localparam int CTRL_NHYST_HI   = 1;
  localparam int CTRL_NHYST_LO   = 0;

  // mode register fields
  localparam int MODE_UP_IE_BIT   = 5;
  localparam int MODE_DOWN_IE_BIT = 4;
  localparam int MODE_RESP_HI     = 1;
  localparam int MODE_RESP_LO     = 0;

  // reset source register field
  localparam int RESET_SEL_BIT = 0;

  // reset values
  localparam logic       ON_RESET      = 1'b0;
  localparam logic       FLAG_RESET    = 1'b0;
  localparam logic       IE_RESET      = 1'b0;
  localparam logic       SEL_RESET     = 1'b0;
  localparam logic [1:0] HYST_RESET    = 2'h0;
  localparam logic [1:0] RESP_RESET    = 2'h2;
  localparam logic [7:0] RDATA_RESET   = 8'h00;

  // hysteresis codes
  typedef enum logic [1:0] {
    HYST_NONE = 2'h0,
    HYST_5MV  = 2'h1,
    HYST_10MV = 2'h2,
    HYST_20MV = 2'h3
  } hyst_type;

  // response codes, fastest to slowest
  typedef enum logic [1:0] {
    RESP_FASTEST = 2'h0,
    RESP_MODE1   = 2'h1,
    RESP_MODE2   = 2'h2,
    RESP_SLOWEST = 2'h3
  } resp_type;
endpackage

// [cmp_sync.sv]
// three-stage synchroniser with agreement filter
module cmp_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // asynchronous input
  input  wire logic asyncIn,
  // filtered level in clk domain
  output logic      syncOut
);
  logic s1Q;  // first stage, read only by s2Q
  logic s2Q;  // second stage
  logic s3Q;  // third stage
  logic outQ; // accepted level

  // shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Q <= 1'b0;
      s2Q <= 1'b0;
      s3Q <= 1'b0;
    end else begin
      s1Q <= asyncIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  // change taken once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outQ <= 1'b0;
    end else if (s2Q == s3Q) begin
      outQ <= s3Q;
    end
  end

  assign syncOut = outQ;
endmodule

// [voltage_comparator_control.sv]
// digital control and status around the analog comparator
module voltage_comparator_control #(
  parameter int ADDR_W = 8  // register address width
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wrData,
  input  wire logic              wrEn,
  input  wire logic              rdEn,
  output logic      [7:0]        rdData,
  // analog core
  input  wire logic              cmpAnalog,
  output logic                   cmpPowerOn,
  output logic      [1:0]        posHyst,
  output logic      [1:0]        negHyst,
  output logic      [1:0]        responseMode,
  // pin outputs
  output logic                   latchedCmpOut,
  output logic                   rawCmpOut,
  // interrupt request and reset source
  output logic                   cmpIrq,
  output logic                   cmpResetReq
);

  // refuse address widths too narrow for the map
  if (ADDR_W < 8) begin : g_addr_chk
    $error("address width below eight bits");
  end

  // control register state
  logic       onQ;          // comparator on
  logic       upFlagQ;      // sticky rising flag
  logic       downFlagQ;    // sticky falling flag
  logic [1:0] posHystQ;     // positive hysteresis code
  logic [1:0] negHystQ;     // negative hysteresis code
  // mode register state
  logic       upIrqEnQ;     // rising interrupt enable
  logic       downIrqEnQ;   // falling interrupt enable
  logic [1:0] respQ;        // response mode code
  // reset source select
  logic       resetSelQ;    // comparator chosen as reset source
  // output path
  logic       syncOut;      // synchronised comparator level
  logic       prevQ;        // level seen last cycle
  logic       latchedQ;     // latched pin output
  logic [7:0] rdDataQ;      // read data register
  // decode and event terms
  logic       ctrlWr;       // write to control register
  logic       modeWr;       // write to mode register
  logic       resetWr;      // write to reset select register
  logic       riseEvt;      // rising edge this cycle
  logic       fallEvt;      // falling edge this cycle
  logic       compareResult; // level shown to software
  logic       upFlagD;      // next rising flag
  logic       downFlagD;    // next falling flag
  logic [7:0] rdDataD;      // next read data

  // address decode
  assign ctrlWr  = wrEn && (addr == ADDR_W'(cmp_pkg::CTRL_ADDR));
  assign modeWr  = wrEn && (addr == ADDR_W'(cmp_pkg::MODE_ADDR));
  assign resetWr = wrEn && (addr == ADDR_W'(cmp_pkg::RESET_ADDR));

  // bring the asynchronous comparator level into clk
  cmp_sync u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (cmpAnalog),
    .syncOut (syncOut)
  );

  // enable bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      onQ <= cmp_pkg::ON_RESET;
    end else if (ctrlWr) begin
      onQ <= wrData[cmp_pkg::CTRL_ON_BIT];
    end
  end

  // hysteresis fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      posHystQ <= cmp_pkg::HYST_RESET;
      negHystQ <= cmp_pkg::HYST_RESET;
    end else if (ctrlWr) begin
      posHystQ <= wrData[cmp_pkg::CTRL_PHYST_HI:cmp_pkg::CTRL_PHYST_LO];
      negHystQ <= wrData[cmp_pkg::CTRL_NHYST_HI:cmp_pkg::CTRL_NHYST_LO];
    end
  end

  // mode register fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upIrqEnQ   <= cmp_pkg::IE_RESET;
      downIrqEnQ <= cmp_pkg::IE_RESET;
      respQ      <= cmp_pkg::RESP_RESET;
    end else if (modeWr) begin
      upIrqEnQ   <= wrData[cmp_pkg::MODE_UP_IE_BIT];
      downIrqEnQ <= wrData[cmp_pkg::MODE_DOWN_IE_BIT];
      respQ      <= wrData[cmp_pkg::MODE_RESP_HI:cmp_pkg::MODE_RESP_LO];
    end
  end

  // reset source select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetSelQ <= cmp_pkg::SEL_RESET;
    end else if (resetWr) begin
      resetSelQ <= wrData[cmp_pkg::RESET_SEL_BIT];
    end
  end

  // analog core controls
  assign cmpPowerOn   = onQ;
  assign posHyst      = posHystQ;
  assign negHyst      = negHystQ;
  assign responseMode = respQ;

  // level shown to software, zero while off
  assign compareResult = onQ & syncOut;

  // previous level for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevQ <= 1'b0;
    end else begin
      prevQ <= compareResult;
    end
  end

  // edges on the synchronised level, only while on
  assign riseEvt = onQ && compareResult && !prevQ;
  assign fallEvt = onQ && !compareResult && prevQ;

  // sticky flags: hardware set beats a software clear
  always_comb begin
    upFlagD   = upFlagQ;
    downFlagD = downFlagQ;
    if (ctrlWr) begin
      upFlagD   = wrData[cmp_pkg::CTRL_UP_BIT];
      downFlagD = wrData[cmp_pkg::CTRL_DOWN_BIT];
    end
    if (riseEvt) begin
      upFlagD = 1'b1;
    end
    if (fallEvt) begin
      downFlagD = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upFlagQ   <= cmp_pkg::FLAG_RESET;
      downFlagQ <= cmp_pkg::FLAG_RESET;
    end else begin
      upFlagQ   <= upFlagD;
      downFlagQ <= downFlagD;
    end
  end

  // interrupt request, each flag gated by its enable
  assign cmpIrq = (upFlagQ && upIrqEnQ)
               || (downFlagQ && downIrqEnQ);

  // clocked pin output, low from the very edge that disables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latchedQ <= 1'b0;
    end else if (ctrlWr && !wrData[cmp_pkg::CTRL_ON_BIT]) begin
      latchedQ <= 1'b0;
    end else begin
      latchedQ <= compareResult;
    end
  end
  assign latchedCmpOut = latchedQ;

  // raw pin output needs no clock edge to follow
  assign rawCmpOut = onQ & cmpAnalog;

  // reset request while on, low output and selected
  assign cmpResetReq = onQ && resetSelQ && !syncOut;

  // read mux
  always_comb begin
    rdDataD = 8'h00;
    if (addr == ADDR_W'(cmp_pkg::CTRL_ADDR)) begin
      rdDataD[cmp_pkg::CTRL_ON_BIT]     = onQ;
      rdDataD[cmp_pkg::CTRL_RESULT_BIT] = compareResult;
      rdDataD[cmp_pkg::CTRL_UP_BIT]     = upFlagQ;
      rdDataD[cmp_pkg::CTRL_DOWN_BIT]   = downFlagQ;
      rdDataD[cmp_pkg::CTRL_PHYST_HI:cmp_pkg::CTRL_PHYST_LO] = posHystQ;
      rdDataD[cmp_pkg::CTRL_NHYST_HI:cmp_pkg::CTRL_NHYST_LO] = negHystQ;
    end else if (addr == ADDR_W'(cmp_pkg::MODE_ADDR)) begin
      rdDataD[cmp_pkg::MODE_UP_IE_BIT]   = upIrqEnQ;
      rdDataD[cmp_pkg::MODE_DOWN_IE_BIT] = downIrqEnQ;
      rdDataD[cmp_pkg::MODE_RESP_HI:cmp_pkg::MODE_RESP_LO] = respQ;
    end else if (addr == ADDR_W'(cmp_pkg::RESET_ADDR)) begin
      rdDataD[cmp_pkg::RESET_SEL_BIT] = resetSelQ;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataQ <= cmp_pkg::RDATA_RESET;
    end else if (rdEn) begin
      rdDataQ <= rdDataD;
    end else begin
      rdDataQ <= cmp_pkg::RDATA_RESET;
    end
  end
  assign rdData = rdDataQ;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  power_follow_a: assert property (
    ctrlWr |=> cmpPowerOn == $past(wrData[cmp_pkg::CTRL_ON_BIT]))
    else $error("power does not follow enable write");

  result_read_a: assert property (
    rdEn && addr == ADDR_W'(cmp_pkg::CTRL_ADDR)
      |=> rdData[cmp_pkg::CTRL_RESULT_BIT] == $past(onQ && syncOut))
    else $error("result bit wrong on read");

  up_set_a: assert property (
    onQ && syncOut && !prevQ |=> upFlagQ)
    else $error("rising edge not flagged");

  down_set_a: assert property (
    onQ && !syncOut && prevQ |=> downFlagQ)
    else $error("falling edge not flagged");

  flag_hold_a: assert property (
    upFlagQ && !ctrlWr |=> upFlagQ)
    else $error("rising flag dropped by hardware");

  down_hold_a: assert property (
    downFlagQ && !ctrlWr |=> downFlagQ)
    else $error("falling flag dropped by hardware");

  irq_up_a: assert property (
    onQ && syncOut && !prevQ && upIrqEnQ && !modeWr |=> cmpIrq)
    else $error("rising interrupt missing");

  irq_gate_a: assert property (
    onQ && !syncOut && prevQ && downIrqEnQ && !modeWr |=> cmpIrq)
    else $error("falling interrupt missing");

  hyst_field_a: assert property (
    ctrlWr |=> posHyst == $past(wrData[cmp_pkg::CTRL_PHYST_HI:cmp_pkg::CTRL_PHYST_LO]))
    else $error("hysteresis field misplaced");

  neg_hyst_a: assert property (
    ctrlWr |=> negHyst == $past(wrData[cmp_pkg::CTRL_NHYST_HI:cmp_pkg::CTRL_NHYST_LO]))
    else $error("negative hysteresis misplaced");

  pin_low_a: assert property (
    !onQ |-> !rawCmpOut && !latchedCmpOut)
    else $error("pin output high while disabled");

  latch_follow_a: assert property (
    onQ |-> latchedCmpOut == $past(onQ && syncOut))
    else $error("latched output not one edge behind");

  raw_follow_a: assert property (
    cmpPowerOn && cmpAnalog |-> rawCmpOut)
    else $error("raw output not following comparator");

  off_quiet_a: assert property (
    !onQ && !ctrlWr |=> $stable(upFlagQ) && $stable(downFlagQ))
    else $error("flag moved while comparator off");

  up_clear_a: assert property (
    ctrlWr && !wrData[cmp_pkg::CTRL_UP_BIT] && !riseEvt |=> !upFlagQ)
    else $error("rising flag not cleared by write");

  irq_en_a: assert property (
    modeWr |=> upIrqEnQ == $past(wrData[cmp_pkg::MODE_UP_IE_BIT])
      && downIrqEnQ == $past(wrData[cmp_pkg::MODE_DOWN_IE_BIT]))
    else $error("interrupt enables misplaced");

  resp_hold_a: assert property (
    !modeWr |=> $stable(responseMode))
    else $error("response mode changed without write");

  read_idle_a: assert property (
    !rdEn |=> rdData == cmp_pkg::RDATA_RESET)
    else $error("read data outside its cycle");

  set_wins_a: assert property (
    onQ && !syncOut && prevQ && ctrlWr |=> downFlagQ)
    else $error("clear beat a falling edge");

  resp_field_a: assert property (
    modeWr |=> responseMode == $past(wrData[cmp_pkg::MODE_RESP_HI:cmp_pkg::MODE_RESP_LO]))
    else $error("response mode not forwarded");

  reset_src_a: assert property (
    cmpResetReq |-> cmpPowerOn && !compareResult && resetSelQ)
    else $error("reset request without selection");

endmodule

// [cmp_core_model.sv]
// behavioural analog comparator core on the far side of the block
module cmp_core_model (
  // controls from the block
  input  wire logic       powerOn,
  input  wire logic [1:0] posHyst,
  input  wire logic [1:0] negHyst,
  input  wire logic [1:0] responseMode,
  // wanted outcome, high when plus above minus
  input  wire logic       level,
  // comparator decision
  output logic            cmpAnalog
);
  timeunit 1ns;
  timeprecision 1ps;

  logic outQ = 1'b0;  // settled decision while powered
  logic junk = 1'b0;  // wandering output while unpowered

  // unpowered core gives nothing trustworthy
  always #13 junk = ~junk;

  // slower modes settle later, mode 3 the slowest
  always @(level or powerOn or responseMode) begin
    if (powerOn) begin
      outQ <= #(5 * (responseMode + 1)) level;
    end
  end

  // decision only meaningful while supplied
  assign cmpAnalog = powerOn ? outQ : junk;
endmodule

// [voltage_comparator_control_tb_top.sv]
// self-checking bench for the comparator control block
module voltage_comparator_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 1'b0;        // system clock
  logic       clkRun = 1'b1;     // clock gate for stop test
  logic       rst_n = 1'b0;      // reset, active low
  logic [7:0] addr = 8'h00;      // register address
  logic [7:0] wrData = 8'h00;    // write data
  logic       wrEn = 1'b0;       // write strobe
  logic       rdEn = 1'b0;       // read strobe
  logic       rdWas = 1'b0;      // read taken last edge
  logic       lvl = 1'b0;        // wanted comparator outcome
  logic [7:0] rdData;            // read data
  logic       cmpAnalog;         // core decision
  logic       cmpPowerOn;        // core supply
  logic [1:0] posHyst;           // positive hysteresis code
  logic [1:0] negHyst;           // negative hysteresis code
  logic [1:0] responseMode;      // response code
  logic       latchedCmpOut;     // clocked pin output
  logic       rawCmpOut;         // unclocked pin output
  logic       cmpIrq;            // interrupt request
  logic       cmpResetReq;       // reset request
  logic [7:0] expQ[$];           // expected read data
  logic [31:0] seed = 32'hD018;  // xorshift state
  int         err_count = 0;     // mismatches
  int         samples_checked = 0; // comparisons

  // 25 MHz clock, stoppable
  always #20 if (clkRun) clk = ~clk;

  voltage_comparator_control #(.ADDR_W(8)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .cmpAnalog(cmpAnalog),
    .cmpPowerOn(cmpPowerOn), .posHyst(posHyst), .negHyst(negHyst),
    .responseMode(responseMode), .latchedCmpOut(latchedCmpOut),
    .rawCmpOut(rawCmpOut), .cmpIrq(cmpIrq), .cmpResetReq(cmpResetReq)
  );

  cmp_core_model core (
    .powerOn(cmpPowerOn), .posHyst(posHyst), .negHyst(negHyst),
    .responseMode(responseMode), .level(lvl), .cmpAnalog(cmpAnalog)
  );

  // xorshift source of stimulus values
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // wait whole cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle write, then one idle edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    cyc(1);
    wrEn <= 1'b0;
    cyc(1);
  endtask

  // one-cycle read, expected value noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    addr <= a;
    rdEn <= 1'b1;
    cyc(1);
    rdEn <= 1'b0;
    cyc(1);
  endtask

  // end of run
  task automatic results();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // read data is valid only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdWas && expQ.size() > 0) begin
      check(rdData, expQ.pop_front());
    end
    rdWas <= rdEn;
  end

  // hang guard
  initial begin
    #100000;
    err_count++;
    results();
  end

  // main sequence
  initial begin
    logic [7:0] r;  // random mode value
    logic [1:0] h;  // hysteresis code
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    // reset values, unmapped address
    rd(cmp_pkg::CTRL_ADDR, 8'h00);
    rd(cmp_pkg::MODE_ADDR, 8'h02);
    rd(cmp_pkg::RESET_ADDR, 8'h00);
    rd(8'h10, 8'h00);
    check({cmpPowerOn, latchedCmpOut, rawCmpOut, cmpIrq, cmpResetReq, responseMode,
           1'b0}, 8'h04);
    $display("test reset done");
    // every hysteresis and response code, random upper bits
    for (int i = 0; i < 4; i++) begin
      h = 2'(i);
      r = xs();
      r[1:0] = h;
      wr(cmp_pkg::CTRL_ADDR, {4'h0, h, ~h});
      wr(cmp_pkg::MODE_ADDR, r);
      rd(cmp_pkg::MODE_ADDR, r & 8'h33);
      rd(cmp_pkg::CTRL_ADDR, {4'h0, h, ~h});
      check({posHyst, negHyst, responseMode, 2'b00}, {h, ~h, h, 2'b00});
    end
    $display("test codes done");
    // edges, masking, sticky flags
    wr(cmp_pkg::MODE_ADDR, 8'h00);
    lvl <= 1'b1;
    wr(cmp_pkg::CTRL_ADDR, 8'h80);
    cyc(10);
    wr(cmp_pkg::CTRL_ADDR, 8'h80);
    rd(cmp_pkg::CTRL_ADDR, 8'hC0);
    check({5'h0, cmpPowerOn, rawCmpOut, latchedCmpOut}, 8'h07);
    lvl <= 1'b0;
    cyc(10);
    rd(cmp_pkg::CTRL_ADDR, 8'h90);
    check({7'h0, cmpIrq}, 8'h00);
    wr(cmp_pkg::MODE_ADDR, 8'h10);
    check({7'h0, cmpIrq}, 8'h01);
    cyc(20);
    rd(cmp_pkg::CTRL_ADDR, 8'h90);
    wr(cmp_pkg::CTRL_ADDR, 8'h80);
    check({7'h0, cmpIrq}, 8'h00);
    wr(cmp_pkg::MODE_ADDR, 8'h20);
    lvl <= 1'b1;
    cyc(10);
    rd(cmp_pkg::CTRL_ADDR, 8'hE0);
    check({6'h0, cmpIrq, cmpResetReq}, 8'h02);
    $display("test edges done");
    // comparator as reset source
    wr(cmp_pkg::RESET_ADDR, 8'h01);
    rd(cmp_pkg::RESET_ADDR, 8'h01);
    check({7'h0, cmpResetReq}, 8'h00);
    lvl <= 1'b0;
    cyc(10);
    check({7'h0, cmpResetReq}, 8'h01);
    $display("test reset source done");
    // disabled comparator: outputs low, edges ignored
    lvl <= 1'b1;
    cyc(10);
    wr(cmp_pkg::CTRL_ADDR, 8'h00);
    cyc(4);
    check({4'h0, cmpPowerOn, rawCmpOut, latchedCmpOut, cmpResetReq}, 8'h00);
    lvl <= 1'b0;
    cyc(10);
    lvl <= 1'b1;
    cyc(10);
    rd(cmp_pkg::CTRL_ADDR, 8'h00);
    $display("test disable done");
    // raw output follows with the clock stopped
    wr(cmp_pkg::CTRL_ADDR, 8'h80);
    cyc(10);
    clkRun = 1'b0;
    #100 lvl = 1'b0;
    #100 check({7'h0, rawCmpOut}, 8'h00);
    lvl = 1'b1;
    #100 check({7'h0, rawCmpOut}, 8'h01);
    clkRun = 1'b1;
    cyc(4);
    $display("test stopped clock done");
    results();
  end
endmodule
